// >>> dtm_pkg.sv
// Purpose: Shared constants and types for the dual counter/timer block
// Assumes: 8-bit special-function register port, one 25 MHz clock
// Notes:   Offsets other than timer_control are placed by the team
package dtm_pkg;

    // Register offsets on the special-function register port
    localparam logic [7:0] TIMER_CONTROL_OFF   = 8'h88;
    localparam logic [7:0] TIMER_MODE_OFF      = 8'h89;
    localparam logic [7:0] COUNT_LOW_A_OFF     = 8'h8a;
    localparam logic [7:0] COUNT_LOW_B_OFF     = 8'h8b;
    localparam logic [7:0] COUNT_HIGH_A_OFF    = 8'h8c;
    localparam logic [7:0] COUNT_HIGH_B_OFF    = 8'h8d;
    localparam logic [7:0] CLOCK_SCALE_OFF     = 8'h8e;
    localparam logic [7:0] IRQ_ENABLE_OFF      = 8'ha8;
    localparam logic [7:0] EXT_IRQ_PIN_CFG_OFF = 8'he4;

    // Value of every register after reset
    localparam logic [7:0] REG_RESET = 8'h00;

    // timer_control: run bit and overflow flag of timer A, timer B two above
    localparam int TCTL_RUN_A    = 4;
    localparam int TCTL_FLAG_A   = 5;
    localparam int TCTL_STRIDE   = 2;
    // timer_mode_reg: one nibble per timer, timer B in the upper nibble
    localparam int MODE_SEL_LSB  = 0;
    localparam int MODE_CTS      = 2;
    localparam int MODE_GATE     = 3;
    localparam int MODE_STRIDE   = 4;
    // clock_scale_control: scale field and one system clock select per timer
    localparam int CKS_SCALE_LSB = 0;
    localparam int CKS_SYS_A     = 2;
    // irq_enable_reg and ext_irq_pin_config bit positions
    localparam int IEN_A         = 1;
    localparam int IEN_STRIDE    = 2;
    localparam int POL_A         = 3;
    localparam int POL_STRIDE    = 4;

    // Scaled clock divisors, selected by the clock scale field
    localparam logic [5:0] DIV_SCALE0 = 6'd12;
    localparam logic [5:0] DIV_SCALE1 = 6'd4;
    localparam logic [5:0] DIV_SCALE2 = 6'd48;
    localparam logic [5:0] DIV_SCALE3 = 6'd8;

    // Operating modes from the mode select bits
    typedef enum logic [1:0] {
        DTM_MODE13 = 2'b00,
        DTM_MODE16 = 2'b01,
        DTM_MODE8R = 2'b10,
        DTM_HALT   = 2'b11
    } dtm_mode_t;

endpackage : dtm_pkg

// >>> dtm_channel.sv
// Purpose: One counter/timer channel: count register, stepping, overflow
// Assumes: Step qualification is done by the caller
// Notes:   Byte writes override the stepped value in the same cycle
`timescale 1ns/1ps
`default_nettype none
module dtm_channel
    import dtm_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire dtm_pkg::dtm_mode_t mode,
    input  wire logic              step,
    input  wire logic              wr_low,
    input  wire logic              wr_high,
    input  wire logic [7:0]        wdata,
    output logic      [15:0]       count_q,
    output logic                   ovf
);
    logic [15:0] count_d;
    logic [12:0] inc13;

    // Next count per mode, then software byte writes on top
    always_comb begin
        count_d = count_q;
        ovf     = 1'b0;
        inc13   = {count_q[15:8], count_q[4:0]} + 13'h1;
        if (step) begin
            case (mode)
                DTM_MODE13: begin
                    // Upper three low-byte bits are left as they are
                    count_d = {inc13[12:5], count_q[7:5], inc13[4:0]};
                    ovf     = &{count_q[15:8], count_q[4:0]};
                end
                DTM_MODE16: begin
                    count_d = count_q + 16'h1;
                    ovf     = &count_q;
                end
                DTM_MODE8R: begin
                    // Low byte reloads from the high byte on wrap
                    ovf = &count_q[7:0];
                    count_d[7:0] = ovf ? count_q[15:8] : count_q[7:0] + 8'h1;
                end
                default: begin
                    count_d = count_q;
                end
            endcase
        end
        // Write wins over the step for the byte written
        if (wr_low) begin
            count_d[7:0] = wdata;
        end
        if (wr_high) begin
            count_d[15:8] = wdata;
        end
    end

    // Count register, never cleared by the run bit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_q <= 16'h0000;
        end else begin
            count_q <= count_d;
        end
    end

endmodule : dtm_channel
`default_nettype wire

// >>> dtm_top.sv
// Purpose: Dual counter/timer with register port, pin counting and gating
// Assumes: Pins are asynchronous; isr_ack pulses come from the interrupt logic
// Notes:   All three counting modes are fully featured; mode 3 holds the count
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Each timer count is 16 bits, seen as separate low and high bytes.
// - Two mode select bits per timer in timer_mode_reg pick one of four modes.
// - Timers A and B keep separate mode, system clock select and gating settings; the scale field is shared.
// - 13-bit mode: high byte holds top eight bits, low bits 4..0 the rest.
// - Rolling from all ones to zero sets the timer's overflow flag.
// - Overflow flag raises an interrupt only with its enable bit set.
// - Counter select 1: count falling edges on the count pin.
// - Counter select 0 with system clock select 1: count every clock.
// - Both selects 0: count on the scaled clock chosen by the scale field.
// - Count only when run is 1 and gate is 0 or ext input active.
// - Ext input activity follows its polarity bit in ext_irq_pin_config.
// - Timer A run bit is timer_control bit 4.
// - Setting run never clears or reloads the count.
// - Timer B mirrors timer A with its own bits and second ext input.
// - Overflow flag clears by software or when its service routine is entered.
module dtm_top
    import dtm_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata_q,
    input  wire logic       count_pin_a,
    input  wire logic       count_pin_b,
    input  wire logic       ext_irq_input_a,
    input  wire logic       ext_irq_input_b,
    input  wire logic       isr_ack_a,
    input  wire logic       isr_ack_b,
    output logic            irq_req_a_q,
    output logic            irq_req_b_q
);
    import dtm_pkg::*;

    logic [7:0]  ctrl_q;
    logic [7:0]  mode_q;
    logic [7:0]  scale_q;
    logic [7:0]  ien_q;
    logic [7:0]  pincfg_q;
    logic [1:0]  pin_s1_q;
    logic [1:0]  pin_s2_q;
    logic [1:0]  pin_s3_q;
    logic [1:0]  ext_s1_q;
    logic [1:0]  ext_s2_q;
    logic [5:0]  scale_cnt_q;
    logic        scale_tick_q;
    logic [1:0]  irq_q;
    logic [1:0]  fall;
    logic [1:0]  ext_act;
    logic [1:0]  run_en;
    logic [1:0]  tick;
    logic [1:0]  step;
    logic [1:0]  ovf;
    logic [1:0]  ack;
    logic [1:0]  wr_low;
    logic [1:0]  wr_high;
    logic [15:0] count_w [2];
    logic [7:0]  rd_mux;

    // Write strobe decode, used for every register
    function automatic logic wr_hit(input logic [7:0] addr, input logic wr,
                                    input logic [7:0] off);
        wr_hit = wr && (addr == off);
    endfunction : wr_hit

    // 13-bit view of a count register
    function automatic logic [12:0] c13(input logic [15:0] c);
        c13 = {c[15:8], c[4:0]};
    endfunction : c13

    // Divisor for the scaled clock
    function automatic logic [5:0] scale_div(input logic [1:0] sel);
        case (sel)
            2'b00:   scale_div = DIV_SCALE0;
            2'b01:   scale_div = DIV_SCALE1;
            2'b10:   scale_div = DIV_SCALE2;
            default: scale_div = DIV_SCALE3;
        endcase
    endfunction : scale_div

    assign ack     = {isr_ack_b, isr_ack_a};
    assign wr_low  = {wr_hit(sfr_addr, sfr_wr, COUNT_LOW_B_OFF),
                      wr_hit(sfr_addr, sfr_wr, COUNT_LOW_A_OFF)};
    assign wr_high = {wr_hit(sfr_addr, sfr_wr, COUNT_HIGH_B_OFF),
                      wr_hit(sfr_addr, sfr_wr, COUNT_HIGH_A_OFF)};

    // Configuration registers, separate per timer by field except the shared scale field
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode_q   <= REG_RESET;
            scale_q  <= REG_RESET;
            ien_q    <= REG_RESET;
            pincfg_q <= REG_RESET;
        end else begin
            if (wr_hit(sfr_addr, sfr_wr, TIMER_MODE_OFF)) begin
                mode_q <= sfr_wdata;
            end
            if (wr_hit(sfr_addr, sfr_wr, CLOCK_SCALE_OFF)) begin
                scale_q <= sfr_wdata;
            end
            if (wr_hit(sfr_addr, sfr_wr, IRQ_ENABLE_OFF)) begin
                ien_q <= sfr_wdata;
            end
            if (wr_hit(sfr_addr, sfr_wr, EXT_IRQ_PIN_CFG_OFF)) begin
                pincfg_q <= sfr_wdata;
            end
        end
    end

    // timer_control; a hardware overflow beats any clear in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= REG_RESET;
        end else begin
            if (wr_hit(sfr_addr, sfr_wr, TIMER_CONTROL_OFF)) begin
                ctrl_q <= sfr_wdata;
            end
            for (int i = 0; i < 2; i++) begin
                if (ovf[i]) begin
                    ctrl_q[TCTL_FLAG_A + TCTL_STRIDE*i] <= 1'b1;
                end else if (ack[i]) begin
                    ctrl_q[TCTL_FLAG_A + TCTL_STRIDE*i] <= 1'b0;
                end
            end
        end
    end

    // Two-stage pin synchronisers; third stage only for the edge detector
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_s1_q <= 2'b11;
            pin_s2_q <= 2'b11;
            pin_s3_q <= 2'b11;
            ext_s1_q <= 2'b00;
            ext_s2_q <= 2'b00;
        end else begin
            pin_s1_q <= {count_pin_b, count_pin_a};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            ext_s1_q <= {ext_irq_input_b, ext_irq_input_a};
            ext_s2_q <= ext_s1_q;
        end
    end

    // Shared scaled-clock enable; a scale change takes effect on next reload
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scale_cnt_q  <= 6'h00;
            scale_tick_q <= 1'b0;
        end else if (scale_cnt_q == 6'h00) begin
            scale_cnt_q  <= scale_div(scale_q[CKS_SCALE_LSB +: 2]) - 6'h1;
            scale_tick_q <= 1'b1;
        end else begin
            scale_cnt_q  <= scale_cnt_q - 6'h1;
            scale_tick_q <= 1'b0;
        end
    end

    // Per-timer qualification and channel; B is a copy of A
    for (genvar i = 0; i < 2; i++) begin : g_tmr
        localparam int RB = TCTL_RUN_A + TCTL_STRIDE*i;
        localparam int FB = TCTL_FLAG_A + TCTL_STRIDE*i;
        localparam int MB = MODE_STRIDE*i;
        localparam int EB = IEN_A + IEN_STRIDE*i;
        localparam int PB = POL_A + POL_STRIDE*i;

        assign fall[i]    = pin_s3_q[i] & ~pin_s2_q[i];
        assign ext_act[i] = pincfg_q[PB] ? ext_s2_q[i] : ~ext_s2_q[i];
        assign run_en[i]  = ctrl_q[RB] & (~mode_q[MB+MODE_GATE] | ext_act[i]);
        // Source select: pin edge, every clock, or scaled clock
        assign tick[i]    = mode_q[MB+MODE_CTS] ? fall[i] :
                            (scale_q[CKS_SYS_A+i] ? 1'b1 : scale_tick_q);
        assign step[i]    = run_en[i] & tick[i];

        dtm_channel u_chan (
            .sys_clk (sys_clk),
            .rst     (rst),
            .mode    (dtm_mode_t'(mode_q[MB+MODE_SEL_LSB +: 2])),
            .step    (step[i]),
            .wr_low  (wr_low[i]),
            .wr_high (wr_high[i]),
            .wdata   (sfr_wdata),
            .count_q (count_w[i]),
            .ovf     (ovf[i])
        );

        // Interrupt request only while enabled
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                irq_q[i] <= 1'b0;
            end else begin
                irq_q[i] <= ctrl_q[FB] & ien_q[EB];
            end
        end
    end

    assign irq_req_a_q = irq_q[0];
    assign irq_req_b_q = irq_q[1];

    // Read mux; unmapped offsets read zero
    always_comb begin
        case (sfr_addr)
            TIMER_CONTROL_OFF:   rd_mux = ctrl_q;
            TIMER_MODE_OFF:      rd_mux = mode_q;
            COUNT_LOW_A_OFF:     rd_mux = count_w[0][7:0];
            COUNT_LOW_B_OFF:     rd_mux = count_w[1][7:0];
            COUNT_HIGH_A_OFF:    rd_mux = count_w[0][15:8];
            COUNT_HIGH_B_OFF:    rd_mux = count_w[1][15:8];
            CLOCK_SCALE_OFF:     rd_mux = scale_q;
            IRQ_ENABLE_OFF:      rd_mux = ien_q;
            EXT_IRQ_PIN_CFG_OFF: rd_mux = pincfg_q;
            default:             rd_mux = 8'h00;
        endcase
    end

    // Read data registered one cycle after the read strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sfr_rdata_q <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata_q <= rd_mux;
        end
    end

    // Checks on timer A, plus one gate check on timer B
    logic wr_a;
    logic m13_a;
    logic en_a;
    assign wr_a  = wr_low[0] | wr_high[0];
    assign m13_a = (mode_q[MODE_SEL_LSB +: 2] == DTM_MODE13);
    assign en_a  = ctrl_q[TCTL_RUN_A] & ~mode_q[MODE_GATE];

    flag_set_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        ovf[0] |=> ctrl_q[TCTL_FLAG_A]) else $error("overflow did not set flag");
    irq_gate_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        irq_req_a_q |-> $past(ien_q[IEN_A]) && $past(ctrl_q[TCTL_FLAG_A]))
        else $error("interrupt without enable and flag");
    hold_idle_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        !ctrl_q[TCTL_RUN_A] && !wr_a |=> $stable(count_w[0]))
        else $error("count moved while stopped");
    run_noreset_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        $rose(ctrl_q[TCTL_RUN_A]) && !$past(wr_a) |-> count_w[0] == $past(count_w[0]))
        else $error("run bit altered count");
    pin_count_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        en_a && mode_q[MODE_CTS] && fall[0] && m13_a && !wr_a
        |=> c13(count_w[0]) == $past(c13(count_w[0])) + 13'h1)
        else $error("pin edge not counted");
    sysclk_count_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        en_a && !mode_q[MODE_CTS] && scale_q[CKS_SYS_A] && m13_a && !wr_a
        |=> c13(count_w[0]) == $past(c13(count_w[0])) + 13'h1)
        else $error("system clock not counted");
    scale_hold_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        !mode_q[MODE_CTS] && !scale_q[CKS_SYS_A] && !scale_tick_q && !wr_a
        |=> $stable(count_w[0])) else $error("counted without scaled tick");
    byte_write_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        wr_high[0] |=> count_w[0][15:8] == $past(sfr_wdata))
        else $error("high byte write lost");
    isr_clear_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        isr_ack_a && !ovf[0] |=> !ctrl_q[TCTL_FLAG_A]) else $error("ack kept flag");
    wrap_zero_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        ovf[0] && m13_a && !wr_a |=> c13(count_w[0]) == 13'h0000)
        else $error("13-bit wrap not to zero");

    // A closed gate holds the count on either timer, whatever the source
    gate_hold_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        mode_q[MODE_GATE] && !ext_act[0] && !wr_a |=> $stable(count_w[0]))
        else $error("count moved with gate closed");
    gate_b_hold_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        mode_q[MODE_STRIDE+MODE_GATE] && !ext_act[1] && !wr_low[1] && !wr_high[1]
        |=> $stable(count_w[1])) else $error("timer B counted with gate closed");

    ovf_seen_c: cover property (@(posedge sys_clk) disable iff (rst) ovf[0]);
    irq_seen_c: cover property (@(posedge sys_clk) disable iff (rst) irq_req_a_q);
    pin_step_c: cover property (@(posedge sys_clk) disable iff (rst) fall[0] && step[0]);
    gated_c:    cover property (@(posedge sys_clk) disable iff (rst)
                    mode_q[MODE_GATE] && ext_act[0] && step[0]);

endmodule : dtm_top
`default_nettype wire

// >>> dtm_pin_model.sv
// Purpose: Far-side model driving the count pins and gating inputs
// Assumes: Pins idle high; edges launched off the falling clock edge
// Notes:   Each level is held three clocks, above the two-clock minimum
`timescale 1ns/1ps
`default_nettype none
module dtm_pin_model (
    input  wire logic sys_clk,
    output var logic  count_pin_a,
    output var logic  count_pin_b,
    output var logic  ext_irq_input_a,
    output var logic  ext_irq_input_b
);
    // Idle levels from time zero so no false edge reaches the synchronisers
    initial begin
        count_pin_a     = 1'b1;
        count_pin_b     = 1'b1;
        ext_irq_input_a = 1'b0;
        ext_irq_input_b = 1'b0;
    end

    // Falling edges on one pin, each level long enough to be seen
    task automatic pulse(input int which, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge sys_clk);
            if (which == 0) count_pin_a = 1'b0; else count_pin_b = 1'b0;
            repeat (3) @(negedge sys_clk);
            if (which == 0) count_pin_a = 1'b1; else count_pin_b = 1'b1;
            repeat (3) @(negedge sys_clk);
        end
    endtask : pulse

    // Gate input level; slow change so the sync stages settle
    task automatic set_ext(input int which, input logic v);
        @(negedge sys_clk);
        if (which == 0) ext_irq_input_a = v; else ext_irq_input_b = v;
        repeat (4) @(negedge sys_clk);
    endtask : set_ext
endmodule : dtm_pin_model
`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench for the dual counter/timer
// Assumes: Register strobes one cycle each, read data one edge late
// Notes:   Free-running counts are checked within a small window
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dtm_pkg::*;
    logic       sys_clk, rst, sfr_wr, sfr_rd, isr_ack_a, isr_ack_b;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q, d;
    logic       count_pin_a, count_pin_b, ext_irq_input_a, ext_irq_input_b;
    logic       irq_req_a_q, irq_req_b_q;
    logic [12:0] v1, v2;
    int         mismatches, n_checks;
    dtm_top u_dtm_top (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata_q(sfr_rdata_q), .count_pin_a(count_pin_a),
        .count_pin_b(count_pin_b), .ext_irq_input_a(ext_irq_input_a),
        .ext_irq_input_b(ext_irq_input_b), .isr_ack_a(isr_ack_a),
        .isr_ack_b(isr_ack_b), .irq_req_a_q(irq_req_a_q), .irq_req_b_q(irq_req_b_q));
    dtm_pin_model u_dtm_pin_model (.sys_clk(sys_clk), .count_pin_a(count_pin_a),
        .count_pin_b(count_pin_b), .ext_irq_input_a(ext_irq_input_a),
        .ext_irq_input_b(ext_irq_input_b));
    // 25 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8
    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        sfr_addr = a; sfr_wdata = v; sfr_wr = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge sys_clk);
        sfr_addr = a; sfr_rd = 1'b1;
        @(negedge sys_clk);
        sfr_rd = 1'b0;
        @(negedge sys_clk);
        v = sfr_rdata_q;
    endtask : rd
    // 13-bit count view: high byte over low bits 4..0, top low bits masked
    task automatic rd13(input logic [7:0] hi, input logic [7:0] lo, output logic [12:0] v);
        logic [7:0] h, l;
        rd(hi, h);
        rd(lo, l);
        v = {h, l[4:0]};
    endtask : rd13
    task automatic ld13(input logic [7:0] hi, input logic [7:0] lo, input logic [12:0] v);
        wr(hi, v[12:5]);
        wr(lo, {3'h0, v[4:0]});
    endtask : ld13
    // Reset values, byte storage, unmapped access
    task automatic t_regs;
        rd(TIMER_CONTROL_OFF, d); chk8("tctl reset", 8'h00, d);
        rd(COUNT_HIGH_A_OFF, d); chk8("high_a reset", 8'h00, d);
        wr(COUNT_HIGH_A_OFF, 8'h12); rd(COUNT_HIGH_A_OFF, d);
        chk8("high_a rw", 8'h12, d);
        wr(COUNT_LOW_A_OFF, 8'hff); rd(COUNT_LOW_A_OFF, d);
        chk8("low_a bits", 8'h1f, d & 8'h1f);
        rd(COUNT_HIGH_B_OFF, d); chk8("high_b apart", 8'h00, d);
        wr(TIMER_CONTROL_OFF, 8'h0f); rd(TIMER_CONTROL_OFF, d);
        chk8("tctl low bits", 8'h0f, d);
        wr(8'h00, 8'h55); rd(8'h00, d); chk8("unmapped", 8'h00, d);
    endtask : t_regs
    // System clock count through overflow, interrupt gating, flag clear
    task automatic t_ovf;
        wr(TIMER_CONTROL_OFF, 8'h00);
        wr(TIMER_MODE_OFF, 8'h00);
        wr(CLOCK_SCALE_OFF, 8'h04);
        ld13(COUNT_HIGH_A_OFF, COUNT_LOW_A_OFF, 13'h1ffc);
        wr(TIMER_CONTROL_OFF, 8'h10);
        tick(8);
        rd(TIMER_CONTROL_OFF, d); chk8("flag_a set", 8'h30, d & 8'h30);
        chk1("irq masked", 1'b0, irq_req_a_q);
        wr(IRQ_ENABLE_OFF, 8'h02); tick(2);
        chk1("irq raised", 1'b1, irq_req_a_q);
        chk1("irq_b quiet", 1'b0, irq_req_b_q);
        isr_ack_a = 1'b1; tick(1); isr_ack_a = 1'b0; tick(2);
        chk1("irq after ack", 1'b0, irq_req_a_q);
        rd(TIMER_CONTROL_OFF, d); chk8("flag cleared", 8'h00, d & 8'h20);
        wr(TIMER_CONTROL_OFF, 8'h00);
        rd13(COUNT_HIGH_A_OFF, COUNT_LOW_A_OFF, v1);
        chk1("wrap then count", 1'b1, v1 > 13'h0 && v1 < 13'h0060);
        tick(20);
        rd13(COUNT_HIGH_A_OFF, COUNT_LOW_A_OFF, v2);
        chk1("hold stopped", 1'b1, v2 == v1);
        wr(TIMER_CONTROL_OFF, 8'h10); tick(4); wr(TIMER_CONTROL_OFF, 8'h00);
        rd13(COUNT_HIGH_A_OFF, COUNT_LOW_A_OFF, v2);
        chk1("resume", 1'b1, v2 > v1 && v2 < v1 + 13'd12);
        wr(IRQ_ENABLE_OFF, 8'h00);
    endtask : t_ovf
    // Each scale field value over a fixed run of 96 clocks
    task automatic t_scale;
        logic [5:0] dv [4];
        int         e;
        dv = '{DIV_SCALE0, DIV_SCALE1, DIV_SCALE2, DIV_SCALE3};
        for (int s = 0; s < 4; s++) begin
            wr(CLOCK_SCALE_OFF, 8'(s));
            tick(48); // Old divisor must run out before the timed window
            ld13(COUNT_HIGH_A_OFF, COUNT_LOW_A_OFF, 13'h0);
            wr(TIMER_CONTROL_OFF, 8'h10); tick(94); wr(TIMER_CONTROL_OFF, 8'h00);
            rd13(COUNT_HIGH_A_OFF, COUNT_LOW_A_OFF, v1);
            e = 96 / int'(dv[s]);
            chk1("scaled rate", 1'b1, int'(v1) >= e - 1 && int'(v1) <= e + 1);
        end
    endtask : t_scale
    // Mode select: the hold mode leaves the count alone
    task automatic t_mode;
        wr(TIMER_MODE_OFF, 8'h03); wr(CLOCK_SCALE_OFF, 8'h04);
        ld13(COUNT_HIGH_A_OFF, COUNT_LOW_A_OFF, 13'h0);
        wr(TIMER_CONTROL_OFF, 8'h10); tick(20); wr(TIMER_CONTROL_OFF, 8'h00);
        rd13(COUNT_HIGH_A_OFF, COUNT_LOW_A_OFF, v1);
        chk1("hold mode", 1'b1, v1 == 13'h0);
    endtask : t_mode
    // Timer B counting pin edges, then gated by its input at both polarities
    task automatic t_pin_b(input logic [7:0] m, input logic [7:0] pol, input logic ext,
                           input logic [12:0] e, input string nm);
        wr(TIMER_MODE_OFF, m); wr(EXT_IRQ_PIN_CFG_OFF, pol);
        u_dtm_pin_model.set_ext(1, ext);
        u_dtm_pin_model.pulse(1, 3);
        tick(6);
        rd13(COUNT_HIGH_B_OFF, COUNT_LOW_B_OFF, v1);
        chk1(nm, 1'b1, v1 == e);
    endtask : t_pin_b
    task automatic t_gate;
        ld13(COUNT_HIGH_A_OFF, COUNT_LOW_A_OFF, 13'h0);
        ld13(COUNT_HIGH_B_OFF, COUNT_LOW_B_OFF, 13'h0);
        wr(TIMER_CONTROL_OFF, 8'h50);
        t_pin_b(8'h43, 8'h00, 1'b0, 13'd3, "pin count b");
        t_pin_b(8'hc3, 8'h80, 1'b0, 13'd3, "gate closed hi");
        t_pin_b(8'hc3, 8'h80, 1'b1, 13'd6, "gate open hi");
        t_pin_b(8'hc3, 8'h00, 1'b1, 13'd6, "gate closed lo");
        t_pin_b(8'hc3, 8'h00, 1'b0, 13'd9, "gate open lo");
        rd13(COUNT_HIGH_A_OFF, COUNT_LOW_A_OFF, v1);
        chk1("a untouched", 1'b1, v1 == 13'h0);
        wr(TIMER_CONTROL_OFF, 8'h00);
    endtask : t_gate
    // Timer A pin edges, then its gate closed and open at active-high polarity
    task automatic t_pin_a;
        ld13(COUNT_HIGH_A_OFF, COUNT_LOW_A_OFF, 13'h0);
        wr(TIMER_MODE_OFF, 8'h04); wr(TIMER_CONTROL_OFF, 8'h10);
        u_dtm_pin_model.pulse(0, 2); tick(6);
        rd13(COUNT_HIGH_A_OFF, COUNT_LOW_A_OFF, v1);
        chk1("pin count a", 1'b1, v1 == 13'd2);
        wr(EXT_IRQ_PIN_CFG_OFF, 8'h08); wr(TIMER_MODE_OFF, 8'h0c);
        u_dtm_pin_model.pulse(0, 1); tick(6);
        rd13(COUNT_HIGH_A_OFF, COUNT_LOW_A_OFF, v1);
        chk1("gate closed a", 1'b1, v1 == 13'd2);
        u_dtm_pin_model.set_ext(0, 1'b1);
        u_dtm_pin_model.pulse(0, 1); tick(6);
        rd13(COUNT_HIGH_A_OFF, COUNT_LOW_A_OFF, v1);
        chk1("gate open a", 1'b1, v1 == 13'd3);
        u_dtm_pin_model.set_ext(0, 1'b0);
        wr(TIMER_CONTROL_OFF, 8'h00);
    endtask : t_pin_a
    // Watchdog well beyond the eleven hundred or so clocks the tests need
    initial begin
        #(40 * 20000);
        mismatches++;
        give_verdict();
    end
    initial begin
        mismatches = 0; n_checks = 0;
        rst = 1'b1; sfr_wr = 1'b0; sfr_rd = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00;
        isr_ack_a = 1'b0; isr_ack_b = 1'b0;
        tick(6);
        rst = 1'b0;
        t_regs();
        t_ovf();
        t_scale();
        t_mode();
        t_gate();
        t_pin_a();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
